/* inc/timer_params.svh */
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

`define TMR_COUNT       3
`define OFS_CTRL        5'h00
`define OFS_CFG         5'h04
`define OFS_CNT_LO      5'h08
`define OFS_CNT_HI      5'h0C
`define OFS_RLD_LO      5'h10
`define OFS_RLD_HI      5'h14

`define CTRL_CAPTURE    0
`define CTRL_CT_SEL     1
`define CTRL_RUN        2
`define CTRL_TRIG_EN    3
`define CTRL_TRIG_FLAG  6
`define CTRL_OVF        7
`define CTRL_WR_MASK    8'h0F

`define CFG_DCEN        0
`define CFG_TOGGLE_EN   1
`define CFG_TOGGLE_ST   2
`define CFG_CLKSEL_LO   3
`define CFG_CLKSEL_HI   4
`define CFG_WR_MASK     8'h1B

`define CTRL_RESET      8'h00
`define CFG_RESET       8'h00
`define BYTE_RESET      8'h00

`define DIV2_COUNT      2
`define DIV12_COUNT     12
`define EXT_DIV_COUNT   8

`define HAS_TOGGLE      3'h5

`endif

/* inc/timer_pkg.sv */
package timer_pkg;

  typedef enum logic [1:0] {
    CLK_DIV12,
    CLK_SYS,
    CLK_DIV2,
    CLK_EXT_DIV8
  } clock_select_e;

  typedef logic [15:0] count_t;

endpackage

/* rtl/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] fall_o,
  output logic      [WIDTH-1:0] rise_o
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] agree;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign agree = ~(s2_reg ^ s3_reg);

  // Filtered level follows only once the last two stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= '0;
    end else begin
      level_o <= (level_o & ~agree) | (s3_reg & agree);
    end
  end

  assign fall_o = level_o & agree & ~s3_reg;
  assign rise_o = ~level_o & agree & s3_reg;

endmodule

`default_nettype wire

/* rtl/sixteen_bit_updown_timer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "timer_params.svh"

module sixteen_bit_updown_timer #(
  parameter int DIV12   = `DIV12_COUNT,
  parameter int EXT_DIV = `EXT_DIV_COUNT
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        shared_count_input_pin_i,
  input  wire logic        count_input_pin4_i,
  input  wire logic        shared_direction_pin_i,
  input  wire logic        direction_trigger_pin4_i,
  input  wire logic        ext_osc_clk_i,
  output logic      [1:0]  toggle_o,
  output logic      [1:0]  adc_start_o,
  output logic      [2:0]  dac_update_o,
  output logic      [2:0]  uart0_baud_o
);
  import timer_pkg::*;

  localparam int N = `TMR_COUNT;
  localparam logic [N-1:0] TOGGLE_MASK = `HAS_TOGGLE;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  ////////////////////////////////////////////////////////////////////////////
  // Bit order: 0 shared count, 1 count4, 2 shared direction, 3 direction4, 4 ext osc
  logic [4:0] pin_level;
  logic [4:0] pin_fall;
  logic [4:0] pin_rise;

  pin_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   ({ext_osc_clk_i, direction_trigger_pin4_i, shared_direction_pin_i,
                count_input_pin4_i, shared_count_input_pin_i}),
    .level_o (pin_level),
    .fall_o  (pin_fall),
    .rise_o  (pin_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock dividers
  ////////////////////////////////////////////////////////////////////////////
  logic       div2_reg;
  logic [3:0] div12_reg;
  logic [3:0] ext_reg;
  logic       tick_div2;
  logic       tick_div12;
  logic       tick_ext;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div2_reg <= 1'b0;
    end else begin
      div2_reg <= ~div2_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div12_reg <= 4'h0;
    end else if (tick_div12) begin
      div12_reg <= 4'h0;
    end else begin
      div12_reg <= div12_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_reg <= 4'h0;
    end else if (tick_ext) begin
      ext_reg <= 4'h0;
    end else if (pin_rise[4]) begin
      ext_reg <= ext_reg + 4'h1;
    end
  end

  assign tick_div2  = div2_reg;
  assign tick_div12 = (div12_reg == 4'(DIV12 - 1));
  assign tick_ext   = pin_rise[4] && (ext_reg == 4'(EXT_DIV - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone decode
  ////////////////////////////////////////////////////////////////////////////
  logic       wr_commit;
  logic [7:0] wdat;

  // Writes take effect at the edge where the master samples ack
  assign wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign wdat      = wb_dat_i[7:0];

  logic [N-1:0][7:0] ctrl_reg;
  logic [N-1:0][7:0] cfg_reg;
  logic [N-1:0][7:0] cnt_lo_reg;
  logic [N-1:0][7:0] cnt_hi_reg;
  logic [N-1:0][7:0] rld_lo_reg;
  logic [N-1:0][7:0] rld_hi_reg;
  logic [N-1:0]      ovf_pulse_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Timer channels
  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < N; i++) begin : g_tmr
    logic          hit;
    logic          wr_ctrl;
    logic          wr_cfg;
    logic          wr_cnt_lo;
    logic          wr_cnt_hi;
    logic          wr_rld_lo;
    logic          wr_rld_hi;
    logic          cnt_fall;
    logic          dir_level;
    logic          dir_fall;
    logic          dcen;
    logic          capture;
    logic          up;
    logic          clk_tick;
    logic          tick;
    logic          trig;
    logic          ovf;
    logic          load;
    count_t        count;
    count_t        reload;
    count_t        cnt_next;
    clock_select_e clk_sel;

    assign hit       = (wb_adr_i[7:5] == 3'(i)) && (wb_adr_i[1:0] == 2'h0);
    assign wr_ctrl   = wr_commit && hit && (wb_adr_i[4:0] == `OFS_CTRL);
    assign wr_cfg    = wr_commit && hit && (wb_adr_i[4:0] == `OFS_CFG);
    assign wr_cnt_lo = wr_commit && hit && (wb_adr_i[4:0] == `OFS_CNT_LO);
    assign wr_cnt_hi = wr_commit && hit && (wb_adr_i[4:0] == `OFS_CNT_HI);
    assign wr_rld_lo = wr_commit && hit && (wb_adr_i[4:0] == `OFS_RLD_LO);
    assign wr_rld_hi = wr_commit && hit && (wb_adr_i[4:0] == `OFS_RLD_HI);

    // Timer four has its own pins; timers two and three share
    assign cnt_fall  = (i == 2) ? pin_fall[1] : pin_fall[0];
    assign dir_level = (i == 2) ? pin_level[3] : pin_level[2];
    assign dir_fall  = (i == 2) ? pin_fall[3] : pin_fall[2];

    assign dcen    = cfg_reg[i][`CFG_DCEN];
    assign capture = ctrl_reg[i][`CTRL_CAPTURE];
    assign up      = !dcen || dir_level;
    assign clk_sel = clock_select_e'(cfg_reg[i][`CFG_CLKSEL_HI:`CFG_CLKSEL_LO]);
    assign count   = {cnt_hi_reg[i], cnt_lo_reg[i]};
    assign reload  = {rld_hi_reg[i], rld_lo_reg[i]};

    always_comb begin
      unique case (clk_sel)
        CLK_DIV12:    clk_tick = tick_div12;
        CLK_SYS:      clk_tick = 1'b1;
        CLK_DIV2:     clk_tick = tick_div2;
        CLK_EXT_DIV8: clk_tick = tick_ext;
      endcase
    end

    assign tick = ctrl_reg[i][`CTRL_RUN] &&
                  (ctrl_reg[i][`CTRL_CT_SEL] ? cnt_fall : clk_tick);
    // Trigger pin role is dropped while it steers direction
    assign trig = ctrl_reg[i][`CTRL_TRIG_EN] && !dcen && dir_fall;
    assign ovf  = tick && (up ? (count == 16'hFFFF)
                              : (count == (capture ? 16'h0000 : reload)));
    assign load = tick || (trig && !capture);

    always_comb begin
      if (tick && up) begin
        cnt_next = ovf ? (capture ? 16'h0000 : reload) : count + 16'h0001;
      end else if (tick) begin
        cnt_next = ovf ? 16'hFFFF : count - 16'h0001;
      end else begin
        cnt_next = reload;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_lo_reg[i] <= `BYTE_RESET;
        cnt_hi_reg[i] <= `BYTE_RESET;
      end else begin
        if (load) begin
          cnt_lo_reg[i] <= cnt_next[7:0];
          cnt_hi_reg[i] <= cnt_next[15:8];
        end
        if (wr_cnt_lo) begin
          cnt_lo_reg[i] <= wdat;
        end
        if (wr_cnt_hi) begin
          cnt_hi_reg[i] <= wdat;
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        rld_lo_reg[i] <= `BYTE_RESET;
        rld_hi_reg[i] <= `BYTE_RESET;
      end else begin
        if (trig && capture) begin
          rld_lo_reg[i] <= count[7:0];
          rld_hi_reg[i] <= count[15:8];
        end
        if (wr_rld_lo) begin
          rld_lo_reg[i] <= wdat;
        end
        if (wr_rld_hi) begin
          rld_hi_reg[i] <= wdat;
        end
      end
    end

    // Flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ctrl_reg[i] <= `CTRL_RESET;
      end else begin
        if (wr_ctrl) begin
          ctrl_reg[i][3:0] <= 4'(wdat & `CTRL_WR_MASK);
        end
        ctrl_reg[i][5:4] <= 2'h0;
        ctrl_reg[i][`CTRL_OVF] <= ovf ||
          (ctrl_reg[i][`CTRL_OVF] && !(wr_ctrl && !wdat[`CTRL_OVF]));
        ctrl_reg[i][`CTRL_TRIG_FLAG] <= trig ||
          (ctrl_reg[i][`CTRL_TRIG_FLAG] && !(wr_ctrl && !wdat[`CTRL_TRIG_FLAG]));
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cfg_reg[i] <= `CFG_RESET;
      end else begin
        if (wr_cfg) begin
          cfg_reg[i][`CFG_DCEN] <= wdat[`CFG_DCEN];
          cfg_reg[i][`CFG_CLKSEL_HI:`CFG_CLKSEL_LO] <= wdat[`CFG_CLKSEL_HI:`CFG_CLKSEL_LO];
          cfg_reg[i][`CFG_TOGGLE_EN] <= wdat[`CFG_TOGGLE_EN] && TOGGLE_MASK[i];
        end
        cfg_reg[i][7:5] <= 3'h0;
        if (ovf && cfg_reg[i][`CFG_TOGGLE_EN]) begin
          cfg_reg[i][`CFG_TOGGLE_ST] <= ~cfg_reg[i][`CFG_TOGGLE_ST];
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ovf_pulse_reg[i] <= 1'b0;
      end else begin
        ovf_pulse_reg[i] <= ovf;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event outputs
  ////////////////////////////////////////////////////////////////////////////
  assign toggle_o     = {cfg_reg[2][`CFG_TOGGLE_ST], cfg_reg[0][`CFG_TOGGLE_ST]};
  assign adc_start_o  = ovf_pulse_reg[1:0];
  assign dac_update_o = ovf_pulse_reg;
  assign uart0_baud_o = ovf_pulse_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone read and ack
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] rd_byte;
  logic [1:0] rd_idx;

  assign rd_idx = wb_adr_i[6:5];

  always_comb begin
    rd_byte = 8'h00;
    if (!wb_adr_i[7] && (rd_idx < 2'(N)) && (wb_adr_i[1:0] == 2'h0)) begin
      case (wb_adr_i[4:0])
        `OFS_CTRL:   rd_byte = ctrl_reg[rd_idx];
        `OFS_CFG:    rd_byte = cfg_reg[rd_idx];
        `OFS_CNT_LO: rd_byte = cnt_lo_reg[rd_idx];
        `OFS_CNT_HI: rd_byte = cnt_hi_reg[rd_idx];
        `OFS_RLD_LO: rd_byte = rld_lo_reg[rd_idx];
        `OFS_RLD_HI: rd_byte = rld_hi_reg[rd_idx];
        default:     rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

endmodule

`default_nettype wire

/* tb/pin_model.sv */
`timescale 1ns/100ps
`default_nettype none

module pin_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pulse_i,
  input  wire logic dir_i,
  output logic      cnt_o,
  output logic      dir_o,
  output logic      osc_o
);
  logic [2:0] low_cnt;
  logic [1:0] osc_div;

  ////////////////////////////////////////////////////////////////
  // Direction pin follows the bench level one cycle late
  always_ff @(posedge clk_i) begin
    dir_o <= dir_i;
  end

  // Count pin: one falling edge, held low four cycles so the synchroniser sees it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_cnt <= 3'h0;
    end else if (pulse_i) begin
      low_cnt <= 3'h4;
    end else if (low_cnt != 3'h0) begin
      low_cnt <= low_cnt - 3'h1;
    end
  end
  assign cnt_o = (low_cnt == 3'h0);

  // External oscillator runs free at a sixth of the system clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_div <= 2'h0;
      osc_o   <= 1'b0;
    end else if (osc_div == 2'h2) begin
      osc_div <= 2'h0;
      osc_o   <= ~osc_o;
    end else begin
      osc_div <= osc_div + 2'h1;
    end
  end
endmodule

`default_nettype wire

/* tb/timer_asserts.sv */
`timescale 1ns/100ps
`default_nettype none

module timer_asserts #(
  parameter int DIV12   = 12,
  parameter int EXT_DIV = 8
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  adc_start_o,
  input wire logic [2:0]  dac_update_o,
  input wire logic [2:0]  uart0_baud_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  a_ack_prompt: assert property (req |=> wb_ack_o) else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
  a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i[7] |=> wb_dat_o == 32'h0) else $error("unmapped read");
  a_dat_holds: assert property (!req |=> $stable(wb_dat_o)) else $error("read data moved");
  a_adc_dac_tie: assert property (adc_start_o == dac_update_o[1:0]) else $error("adc event mismatch");
  a_baud_dac_tie: assert property (uart0_baud_o == dac_update_o) else $error("baud event mismatch");
endmodule

bind sixteen_bit_updown_timer timer_asserts #(.DIV12(DIV12), .EXT_DIV(EXT_DIV)) u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .adc_start_o, .dac_update_o, .uart0_baud_o);

`default_nettype wire

/* tb/tb_sixteen_bit_updown_timer.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_sixteen_bit_updown_timer;
  import timer_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pulse = 0, dir = 1;
  logic [7:0]  adr = 8'h00, v;
  logic [31:0] dat = 32'h0, wb_dat_o;
  logic        wb_ack_o, cnt_p, dir_p, osc;
  logic [1:0]  toggle_o, adc_start_o;
  logic [2:0]  dac_update_o, uart0_baud_o;
  int          error_cnt = 0, checks = 0, cyc_cnt = 0;
  int          dac_ev = 0, adc_ev = 0, baud_ev = 0;

  always #5 clk_i = ~clk_i;

  sixteen_bit_updown_timer dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o,
    .shared_count_input_pin_i(cnt_p), .count_input_pin4_i(cnt_p), .shared_direction_pin_i(dir_p),
    .direction_trigger_pin4_i(dir_p), .ext_osc_clk_i(osc), .toggle_o, .adc_start_o,
    .dac_update_o, .uart0_baud_o);

  pin_model pins_u (.clk_i, .rst_i, .pulse_i(pulse), .dir_i(dir), .cnt_o(cnt_p), .dir_o(dir_p),
    .osc_o(osc));

  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end

  // Event pulses counted once each, as seen at the edge after launch
  always @(posedge clk_i) begin
    if (dac_update_o[0] === 1'b1) dac_ev++;
    if (adc_start_o[0] === 1'b1) adc_ev++;
    if (uart0_baud_o[2] === 1'b1) baud_ev++;
  end

  task automatic rng(input logic [7:0] lo, input logic [7:0] hi);
    checks++;
    if ($isunknown(v) || v < lo || v > hi) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h..%h", $time, v, lo, hi);
    end
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask

  // Classic single cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    v = wb_dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(v, e);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset_map();
    rc(8'h00, 8'h00);
    rc(8'h24, 8'h00);
    rc(8'h48, 8'h00);
    rc(8'h60, 8'h00);
    rc(8'h80, 8'h00);
    $display("reset and map done");
  endtask

  task automatic t_counter();
    wr(8'h00, 8'h06);
    wr(8'h20, 8'h06);
    repeat (3) begin
      @(posedge clk_i);
      pulse <= 1'b1;
      @(posedge clk_i);
      pulse <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
    rc(8'h08, 8'h03);
    rc(8'h28, 8'h03);
    wr(8'h00, 8'h00);
    wr(8'h20, 8'h00);
    $display("counter mode done");
  endtask

  task automatic t_up_reload();
    wr(8'h04, 8'h0A);
    wr(8'h10, 8'h34);
    wr(8'h14, 8'h12);
    wr(8'h08, 8'hFE);
    wr(8'h0C, 8'hFF);
    wr(8'h00, 8'h04);
    repeat (10) @(posedge clk_i);
    rc(8'h00, 8'h84);
    rc(8'h0C, 8'h12);
    chk({7'h0, toggle_o[0]}, 8'h01);
    chk(8'(dac_ev), 8'h01);
    chk(8'(adc_ev), 8'h01);
    wr(8'h00, 8'h00);
    rc(8'h00, 8'h00);
    $display("up reload done");
  endtask

  task automatic t_down();
    wr(8'h04, 8'h09);
    dir <= 1'b0;
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h08, 8'h03);
    wr(8'h0C, 8'h00);
    wr(8'h00, 8'h04);
    repeat (10) @(posedge clk_i);
    rc(8'h0C, 8'hFF);
    rc(8'h00, 8'h84);
    chk(8'(dac_ev), 8'h02);
    wr(8'h00, 8'h00);
    $display("down count done");
  endtask

  task automatic t_trigger();
    wr(8'h04, 8'h08);
    dir <= 1'b1;
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'h80);
    wr(8'h00, 8'h0D);
    dir <= 1'b0;
    repeat (8) @(posedge clk_i);
    rc(8'h00, 8'h4D);
    rc(8'h14, 8'h80);
    wr(8'h04, 8'h09);
    dir <= 1'b1;
    wr(8'h00, 8'h0D);
    dir <= 1'b0;
    repeat (8) @(posedge clk_i);
    bus(1'b0, 8'h00, 8'h00);
    chk(v & 8'h40, 8'h00);
    wr(8'h00, 8'h00);
    $display("trigger done");
  endtask

  // Timer four: 121 tick chances between run and the read request edge
  task automatic span(input logic [7:0] cfg, input logic [7:0] lo, input logic [7:0] hi);
    wr(8'h48, 8'h00);
    wr(8'h4C, 8'h00);
    wr(8'h44, cfg);
    wr(8'h40, 8'h04);
    repeat (120) @(posedge clk_i);
    bus(1'b0, 8'h48, 8'h00);
    rng(lo, hi);
    wr(8'h40, 8'h00);
  endtask

  task automatic t_clock_sel();
    wr(8'h24, 8'h0A);
    rc(8'h24, 8'h08);
    span(8'h00, 8'h0A, 8'h0B);
    span(8'h10, 8'h3C, 8'h3D);
    span(8'h18, 8'h02, 8'h03);
    wr(8'h44, 8'h0A);
    wr(8'h48, 8'hFF);
    wr(8'h4C, 8'hFF);
    wr(8'h40, 8'h04);
    repeat (4) @(posedge clk_i);
    wr(8'h40, 8'h00);
    chk({7'h0, toggle_o[1]}, 8'h01);
    chk(8'(baud_ev), 8'h01);
    $display("clock select done");
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_map();
    t_counter();
    t_up_reload();
    t_down();
    t_trigger();
    t_clock_sel();
    finish_test();
  end
endmodule

`default_nettype wire
